//--- src/csr_pkg.sv
// package: offsets, field positions, reset values and encodings for the status/option pair
package csr_pkg;
  localparam logic [7:0] STATUS_ADDR_LO   = 8'h03;
  localparam logic [7:0] STATUS_ADDR_HI   = 8'h83;
  localparam logic [7:0] OPTION_ADDR      = 8'h81;
  localparam logic [7:0] TIMER_ADDR       = 8'h01;
  localparam logic [7:0] IRQ_CTRL_ADDR    = 8'h0b;
  localparam int         ST_BANK_BIT      = 5;
  localparam int         ST_TIMEOUT_BIT   = 4;
  localparam int         ST_POWERDOWN_BIT = 3;
  localparam int         ST_ZERO_BIT      = 2;
  localparam int         ST_NIBBLE_BIT    = 1;
  localparam int         ST_CARRY_BIT     = 0;
  localparam int         OPT_PULLUP_BIT   = 7;
  localparam int         OPT_IRQEDGE_BIT  = 6;
  localparam int         OPT_T0SRC_BIT    = 5;
  localparam int         OPT_T0EDGE_BIT   = 4;
  localparam int         OPT_PRE_WDT_BIT  = 3;
  localparam logic [7:0] STATUS_RESET     = 8'h18;
  localparam logic [7:0] OPTION_RESET     = 8'hff;
  localparam logic [7:0] STATUS_WR_MASK   = 8'h27;
  localparam logic [7:0] FLAGS_MASK       = 8'h07;
  localparam int         PRESC_WIDTH      = 8;
  // alu operation codes driven by the core
  typedef enum logic [2:0] {
    CSR_OP_NONE = 3'b000,
    CSR_OP_ADD  = 3'b001,
    CSR_OP_SUB  = 3'b010,
    CSR_OP_LOGIC = 3'b011,
    CSR_OP_ROR  = 3'b100,
    CSR_OP_ROL  = 3'b101
  } csr_op_t;
endpackage

//--- src/csr_if.sv
// interface: alu request and flag results between top and flag unit
`timescale 1ns/1ns
interface csr_alu_if;
  csr_pkg::csr_op_t op;
  logic [7:0]       a;
  logic [7:0]       b;
  logic             carry_in;
  logic [7:0]       result;
  logic             zero;
  logic             nibble;
  logic             carry;
  logic             zc_upd;
  logic             nib_upd;
  modport core (output op, output a, output b, output carry_in,
                input result, input zero, input nibble, input carry,
                input zc_upd, input nib_upd);
  modport alu (input op, input a, input b, input carry_in,
               output result, output zero, output nibble, output carry,
               output zc_upd, output nib_upd);
endinterface

//--- src/csr_alu.sv
// flag unit: alu result plus zero, nibble carry and carry
`timescale 1ns/1ns
module csr_alu (
  csr_alu_if.alu a_if
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] bop;

  always_comb begin
    // subtract as a plus two's complement of b, carry then reads as not-borrow
    bop = (a_if.op == csr_pkg::CSR_OP_SUB) ? (~a_if.b + 8'h01) : a_if.b;
    sum = {1'b0, a_if.a} + {1'b0, bop};
    nib = {1'b0, a_if.a[3:0]} + {1'b0, bop[3:0]};
    a_if.result   = 8'h00;
    a_if.carry    = 1'b0;
    a_if.nibble   = nib[4];
    a_if.zc_upd   = 1'b0;
    a_if.nib_upd  = 1'b0;
    case (a_if.op)
      csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_SUB: begin
        a_if.result = sum[7:0];
        // b of zero on subtract gives carry 1: no borrow
        a_if.carry  = sum[8] | ((a_if.op == csr_pkg::CSR_OP_SUB) && (a_if.b == 8'h00));
        a_if.nibble = nib[4] | ((a_if.op == csr_pkg::CSR_OP_SUB) && (a_if.b[3:0] == 4'h0));
        a_if.zc_upd = 1'b1;
        a_if.nib_upd = 1'b1;
      end
      csr_pkg::CSR_OP_LOGIC: begin
        a_if.result = a_if.a;
        a_if.zc_upd = 1'b1;
      end
      csr_pkg::CSR_OP_ROR: begin
        a_if.result = {a_if.carry_in, a_if.a[7:1]};
        a_if.carry  = a_if.a[0];
      end
      csr_pkg::CSR_OP_ROL: begin
        a_if.result = {a_if.a[6:0], a_if.carry_in};
        a_if.carry  = a_if.a[7];
      end
      default: begin
        a_if.result = 8'h00;
      end
    endcase
    a_if.zero = (a_if.result == 8'h00);
  end
endmodule // csr_alu

//--- src/csr_regs.sv
// top: status and option registers, prescaler, timer0 and edge logic
`timescale 1ns/1ns
module csr_regs #(
  parameter int WDT_WIDTH = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_addr,
  input  wire logic [2:0] alu_op,
  input  wire logic [7:0] alu_a,
  input  wire logic [7:0] alu_b,
  input  wire logic [6:0] direct_addr,
  input  wire logic       instr_tick,
  input  wire logic       wdt_clear,
  input  wire logic       sleep_exec,
  input  wire logic       wdt_timeout,
  input  wire logic       external_irq_pin,
  input  wire logic       external_timer_clock_pin,
  input  wire logic [5:0] port_latch,
  output logic      [7:0] rd_data,
  output logic      [7:0] alu_result,
  output logic      [7:0] full_addr,
  output logic      [7:0] core_status,
  output logic      [7:0] timer_and_pin_options,
  output logic      [5:0] pullup_en,
  output logic            ext_irq_flag,
  output logic      [7:0] timer_zero,
  output logic            timer_zero_overflow,
  output logic            wdt_tick
);
  typedef struct packed {
    logic [7:0]             status;
    logic [7:0]             option;
    logic [7:0]             rd_data;
    logic [7:0]             alu_result;
    logic [7:0]             full_addr;
    logic [5:0]             pullup_en;
    logic                   irq_pin_q;
    logic                   tck_pin_q;
    logic                   ext_irq_flag;
    logic [csr_pkg::PRESC_WIDTH-1:0] presc;
    logic [7:0]             timer;
    logic                   ovf;
    logic [WDT_WIDTH-1:0]   wdt_base;
    logic                   wdt_tick;
  } csr_state_t;

  csr_state_t state_reg;
  csr_state_t state_next;
  csr_alu_if  alu_bus ();

  csr_alu u_alu (
    .a_if (alu_bus)
  );

  // divider tap: returns 1 when the low pow bits of the prescaler are all ones, so the next step wraps them
  function automatic logic presc_wrap(input logic [7:0] cnt, input logic [3:0] pow);
    logic [7:0] mask;
    mask = (8'h01 << pow) - 8'h01;
    presc_wrap = ((cnt & mask) == mask);
  endfunction

  logic       status_sel;
  logic       src_event;
  logic       timer_inc;
  logic       rise_irq;
  logic       fall_irq;
  logic       presc_step;
  logic [3:0] t0_pow;
  logic [3:0] wdt_pow;

  assign alu_bus.op       = csr_pkg::csr_op_t'(alu_op);
  assign alu_bus.a        = alu_a;
  assign alu_bus.b        = alu_b;
  assign alu_bus.carry_in = state_reg.status[csr_pkg::ST_CARRY_BIT];

  always_comb begin
    state_next = state_reg;
    status_sel = (wr_addr == csr_pkg::STATUS_ADDR_LO) || (wr_addr == csr_pkg::STATUS_ADDR_HI);
    t0_pow  = {1'b0, state_reg.option[2:0]} + 4'h1;
    wdt_pow = {1'b0, state_reg.option[2:0]};
    rise_irq = external_irq_pin & ~state_reg.irq_pin_q;
    fall_irq = ~external_irq_pin & state_reg.irq_pin_q;

    // register writes; bank, reserved and the zero, nibble and carry bits take data from software
    if (wr_en && status_sel) begin
      state_next.status = (state_reg.status & ~csr_pkg::STATUS_WR_MASK)
                        | (wr_data & csr_pkg::STATUS_WR_MASK);
      state_next.status[7:6] = wr_data[7:6];
    end
    if (wr_en && (wr_addr == csr_pkg::OPTION_ADDR)) begin
      state_next.option = wr_data;
    end

    // flag results override any data write to the same bits
    if (alu_bus.zc_upd) begin
      state_next.status[csr_pkg::ST_ZERO_BIT] = alu_bus.zero;
    end
    if (alu_bus.nib_upd) begin
      state_next.status[csr_pkg::ST_NIBBLE_BIT] = alu_bus.nibble;
    end
    if (alu_bus.nib_upd || alu_op == csr_pkg::CSR_OP_ROR || alu_op == csr_pkg::CSR_OP_ROL) begin
      state_next.status[csr_pkg::ST_CARRY_BIT] = alu_bus.carry;
    end
    state_next.alu_result = alu_bus.result;

    // reset-status flags move only on their events; time-out wins over clear
    if (wdt_clear) begin
      state_next.status[csr_pkg::ST_TIMEOUT_BIT]   = 1'b1;
      state_next.status[csr_pkg::ST_POWERDOWN_BIT] = 1'b1;
    end
    if (sleep_exec) begin
      state_next.status[csr_pkg::ST_TIMEOUT_BIT]   = 1'b1;
      state_next.status[csr_pkg::ST_POWERDOWN_BIT] = 1'b0;
    end
    if (wdt_timeout) begin
      state_next.status[csr_pkg::ST_TIMEOUT_BIT] = 1'b0;
    end

    // direct address uses the new bank bit one cycle later
    state_next.full_addr = {state_reg.status[csr_pkg::ST_BANK_BIT], direct_addr};

    state_next.pullup_en = state_reg.option[csr_pkg::OPT_PULLUP_BIT] ? 6'h00 : port_latch;

    // edge flag sets regardless of any enable; cleared by writing zero to bit 1 at IRQ_CTRL_ADDR
    state_next.irq_pin_q = external_irq_pin;
    if (state_reg.option[csr_pkg::OPT_IRQEDGE_BIT] ? rise_irq : fall_irq) begin
      state_next.ext_irq_flag = 1'b1;
    end else if (wr_en && wr_addr == csr_pkg::IRQ_CTRL_ADDR) begin
      state_next.ext_irq_flag = wr_data[1];
    end

    // timer0 source select and edge
    state_next.tck_pin_q = external_timer_clock_pin;
    if (state_reg.option[csr_pkg::OPT_T0SRC_BIT]) begin
      src_event = state_reg.option[csr_pkg::OPT_T0EDGE_BIT]
                ? (~external_timer_clock_pin & state_reg.tck_pin_q)
                : (external_timer_clock_pin & ~state_reg.tck_pin_q);
    end else begin
      src_event = instr_tick;
    end

    // one shared prescaler, stepped by whichever side owns it
    presc_step = state_reg.option[csr_pkg::OPT_PRE_WDT_BIT] ? instr_tick : src_event;
    if (presc_step) begin
      state_next.presc = state_reg.presc + 8'h01;
    end
    if (state_reg.option[csr_pkg::OPT_PRE_WDT_BIT]) begin
      timer_inc = src_event;
      state_next.wdt_tick = instr_tick && presc_wrap(state_reg.presc, wdt_pow);
    end else begin
      timer_inc = src_event && presc_wrap(state_reg.presc, t0_pow);
      state_next.wdt_tick = instr_tick;
    end
    state_next.ovf = 1'b0;
    if (timer_inc) begin
      state_next.timer = state_reg.timer + 8'h01;
      state_next.ovf   = (state_reg.timer == 8'hff);
    end
    // writing timer0 or the option register restarts the prescale count
    if (wr_en && (wr_addr == csr_pkg::TIMER_ADDR || wr_addr == csr_pkg::OPTION_ADDR)) begin
      state_next.presc = '0;
      if (wr_addr == csr_pkg::TIMER_ADDR) begin
        state_next.timer = wr_data;
      end
    end
    state_next.wdt_base = '0;

    case (rd_addr)
      csr_pkg::STATUS_ADDR_LO, csr_pkg::STATUS_ADDR_HI: state_next.rd_data = state_next.status;
      csr_pkg::OPTION_ADDR: state_next.rd_data = state_next.option;
      default:              state_next.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg        <= '0;
      state_reg.status <= csr_pkg::STATUS_RESET;
      state_reg.option <= csr_pkg::OPTION_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data               = state_reg.rd_data;
  assign alu_result            = state_reg.alu_result;
  assign full_addr             = state_reg.full_addr;
  assign core_status           = state_reg.status;
  assign timer_and_pin_options = state_reg.option;
  assign pullup_en             = state_reg.pullup_en;
  assign ext_irq_flag          = state_reg.ext_irq_flag;
  assign timer_zero            = state_reg.timer;
  assign timer_zero_overflow   = state_reg.ovf;
  assign wdt_tick              = state_reg.wdt_tick;
endmodule // csr_regs

//--- test/csr_regs_monitor.sv
// checker: port assertions for the status/option register pair
`timescale 1ns/1ns
module csr_regs_monitor (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [2:0] alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [6:0] direct_addr,
  input wire logic       wdt_clear,
  input wire logic       sleep_exec,
  input wire logic       wdt_timeout,
  input wire logic [5:0] port_latch,
  input wire logic [7:0] full_addr,
  input wire logic [7:0] core_status,
  input wire logic [7:0] timer_and_pin_options,
  input wire logic [7:0] timer_zero,
  input wire logic       timer_zero_overflow,
  input wire logic [5:0] pullup_en
);
  logic [8:0] sum_w;
  logic       ev_w;
  assign sum_w = {1'b0, alu_a} + {1'b0, alu_b};
  assign ev_w  = wdt_clear | sleep_exec | wdt_timeout;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_reset_values: assert property (!$past(reset_n) |-> core_status == 8'h18
    && timer_and_pin_options == 8'hff) else $error("reset values wrong");
  a_sleep_flags: assert property (sleep_exec && !wdt_timeout |=>
    core_status[4:3] == 2'b10) else $error("sleep flags wrong");
  a_timeout_clr: assert property (wdt_timeout |=> !core_status[4])
    else $error("timeout flag not cleared");
  a_ro_flags_hold: assert property (!ev_w |=> $stable(core_status[4:3]))
    else $error("read-only flags moved");
  a_addr_form: assert property ($past(reset_n) && $stable(core_status[5]) |->
    full_addr == {core_status[5], $past(direct_addr)}) else $error("direct address wrong");
  a_pullup_gate: assert property ($past(reset_n) && $stable(timer_and_pin_options[7]) |->
    pullup_en == (timer_and_pin_options[7] ? 6'h00 : $past(port_latch)))
    else $error("pull-up enables wrong");
  a_add_carry: assert property (alu_op == 3'h1 |=> core_status[0] == $past(sum_w[8]))
    else $error("add carry wrong");
  a_rotate_carry: assert property (alu_op == 3'h4 |=> core_status[0] == $past(alu_a[0]))
    else $error("rotate carry wrong");
  a_ovf_after_max: assert property (timer_zero_overflow |-> $past(timer_zero) == 8'hff)
    else $error("overflow without wrap");
endmodule // csr_regs_monitor
bind csr_regs csr_regs_monitor u_csr_regs_monitor (.clk_sys, .reset_n, .alu_op, .alu_a,
  .alu_b, .direct_addr, .wdt_clear, .sleep_exec, .wdt_timeout, .port_latch, .full_addr,
  .core_status, .timer_and_pin_options, .pullup_en, .timer_zero, .timer_zero_overflow);

//--- test/csr_core_model.sv
// core-side model: instruction cycle ticks and an external timer clock
`timescale 1ns/1ns
module csr_core_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic run,
  output logic     instr_tick,
  output logic     external_timer_clock_pin
);
  logic [3:0] cnt_reg;
  // everything clears to zero when stopped, so counts can settle before they are read
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !run) begin
      cnt_reg                  <= 4'h0;
      instr_tick               <= 1'b0;
      external_timer_clock_pin <= 1'b0;
    end else begin
      cnt_reg    <= cnt_reg + 4'h1;
      instr_tick <= cnt_reg[1:0] == 2'h3;
      if (cnt_reg[1:0] == 2'h1) begin
        external_timer_clock_pin <= !external_timer_clock_pin;
      end
    end
  end
endmodule // csr_core_model

//--- test/tb_csr_regs.sv
// testbench: status/option registers driven as the core would
`timescale 1ns/1ns
module tb_csr_regs;
  logic       clk_sys, reset_n, wr_en, wdt_clear, sleep_exec, wdt_timeout, run;
  logic       instr_tick, external_irq_pin, external_timer_clock_pin, ext_irq_flag;
  logic       wdt_tick, pin_d, timer_zero_overflow;
  logic [7:0] wr_addr, wr_data, rd_addr, alu_a, alu_b, rd_data, alu_result, full_addr;
  logic [7:0] core_status, timer_and_pin_options, timer_zero, st, r, bb, v, seen;
  logic [6:0] direct_addr;
  logic [5:0] port_latch, pullup_en;
  logic [2:0] alu_op, op;
  logic [8:0] s9;
  logic [4:0] n5;
  logic [10:0] nt;
  logic [10:0] q[$];
  int         n_tick, n_rise, n_fall, n_wdt, n_ovf, n_mismatch, check_count, src, n_inc;

  csr_regs #(.WDT_WIDTH(8)) u_csr_regs (.clk_sys, .reset_n, .wr_en, .wr_addr, .wr_data,
    .rd_addr, .alu_op, .alu_a, .alu_b, .direct_addr, .instr_tick, .wdt_clear, .sleep_exec,
    .wdt_timeout, .external_irq_pin, .external_timer_clock_pin, .port_latch, .rd_data,
    .alu_result, .full_addr, .core_status, .timer_and_pin_options, .pullup_en,
    .ext_irq_flag, .timer_zero, .timer_zero_overflow, .wdt_tick);
  csr_core_model u_csr_core_model (.clk_sys, .reset_n, .run, .instr_tick,
    .external_timer_clock_pin);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] s, input logic [7:0] x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic note(input logic [2:0] s, input logic [7:0] x);
    q.push_back({s, x});
  endtask

  // one bus step: read address follows the write address, events ride along
  task automatic drv(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [2:0] e);
    wr_en = w;
    wr_addr = a;
    wr_data = d;
    rd_addr = a;
    {wdt_clear, sleep_exec, wdt_timeout} = e;
    @(negedge clk_sys);
  endtask

  task automatic tmr(input logic [7:0] o, input logic [7:0] t0);
    drv(1'b1, 8'h81, o, 3'h0);
    drv(1'b1, 8'h01, t0, 3'h0);
    {n_tick, n_rise, n_fall, n_wdt, n_ovf} = '0;
    run = 1'b1;
    repeat (64) drv(1'b0, 8'h00, 8'h00, 3'h0);
    run = 1'b0;
    repeat (5) drv(1'b0, 8'h00, 8'h00, 3'h0);
    src = o[5] ? (o[4] ? n_fall : n_rise) : n_tick;
    n_inc = o[3] ? src : src >> (int'(o[2:0]) + 1);
    note(3'h4, 8'(int'(t0) + n_inc));
    // overflow count rides in the top bits; the watchdog count stays below 32 here
    note(3'h5, {3'(int'(t0) + n_inc > 255),
                5'(o[3] ? n_tick >> o[2:0] : n_tick)});
    drv(1'b0, 8'h00, 8'h00, 3'h0);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    pin_d  <= external_timer_clock_pin;
    n_tick <= n_tick + int'(instr_tick);
    n_rise <= n_rise + int'(external_timer_clock_pin && !pin_d);
    n_fall <= n_fall + int'(!external_timer_clock_pin && pin_d);
    n_wdt  <= n_wdt + int'(wdt_tick);
    n_ovf  <= n_ovf + int'(timer_zero_overflow);
  end

  // results settle just after the edge; drivers move only on the falling edge
  always @(posedge clk_sys) begin
    #1;
    while (q.size() > 0) begin
      nt = q.pop_front();
      case (nt[10:8])
        3'h0: seen = rd_data;
        3'h1: seen = core_status;
        3'h2: seen = alu_result;
        3'h3: seen = {7'h00, ext_irq_flag};
        3'h4: seen = timer_zero;
        3'h5: seen = {n_ovf[2:0], n_wdt[4:0]};
        3'h6: seen = {2'b00, pullup_en};
        default: seen = full_addr;
      endcase
      check(seen, nt[7:0]);
    end
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {wr_en, wr_addr, wr_data, rd_addr, alu_op, alu_a, alu_b, direct_addr} = '0;
    {wdt_clear, sleep_exec, wdt_timeout, external_irq_pin, port_latch, run} = '0;
    reset_n = 1'b0;
    void'($urandom(63980));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    note(3'h0, 8'h18); drv(1'b0, 8'h03, 8'h00, 3'h0);
    note(3'h0, 8'h18); drv(1'b0, 8'h83, 8'h00, 3'h0);
    note(3'h0, 8'hff); drv(1'b0, 8'h81, 8'h00, 3'h0);
    note(3'h0, 8'h00); drv(1'b0, 8'h55, 8'h00, 3'h0);
    v = 8'($urandom);
    drv(1'b1, 8'h81, v, 3'h0);
    note(3'h0, v); drv(1'b0, 8'h81, 8'h00, 3'h0);
    drv(1'b1, 8'h81, 8'h08, 3'h0);
    note(3'h1, 8'h08); drv(1'b0, 8'h03, 8'h00, 3'h1);
    note(3'h1, 8'h10); drv(1'b0, 8'h03, 8'h00, 3'h2);
    note(3'h1, 8'h37); drv(1'b1, 8'h03, 8'h2f, 3'h0);
    note(3'h1, 8'h3f); drv(1'b0, 8'h03, 8'h00, 3'h4);
    note(3'h0, 8'h2f); drv(1'b0, 8'h83, 8'h00, 3'h1);
    note(3'h1, 8'h37); drv(1'b0, 8'h03, 8'h00, 3'h6);
    st = 8'h37;
    for (int i = 0; i < 24; i++) begin
      op = 3'($urandom_range(5, 1));
      {alu_a, alu_b} = 16'($urandom);
      direct_addr = 7'($urandom);
      port_latch = 6'($urandom);
      alu_op = op;
      wr_en = op == 3'h1;
      wr_addr = 8'h03;
      wr_data = {2'b00, st[5], 5'h1f};
      bb = (op == 3'h2) ? ~alu_b : alu_b;
      s9 = {1'b0, alu_a} + {1'b0, bb} + 9'(op == 3'h2);
      n5 = {1'b0, alu_a[3:0]} + {1'b0, bb[3:0]} + 5'(op == 3'h2);
      r = (op == 3'h3) ? alu_a : (op == 3'h4) ? {st[0], alu_a[7:1]} :
          (op == 3'h5) ? {alu_a[6:0], st[0]} : s9[7:0];
      if (op < 3'h3) st[1:0] = {n5[4], s9[8]};
      if (op > 3'h3) st[0] = (op == 3'h4) ? alu_a[0] : alu_a[7];
      if (op < 3'h4) st[2] = r == 8'h00;
      note(3'h2, r);
      note(3'h1, st);
      note(3'h6, {2'b00, port_latch});
      note(3'h7, {st[5], direct_addr});
      @(negedge clk_sys);
    end
    alu_op = 3'h0;
    for (int e = 1; e >= 0; e--) begin
      drv(1'b1, 8'h81, {1'b0, e[0], 6'h08}, 3'h0);
      drv(1'b1, 8'h0b, 8'h00, 3'h0);
      external_irq_pin = 1'b1;
      repeat (3) drv(1'b0, 8'h00, 8'h00, 3'h0);
      note(3'h3, {7'h00, e[0]}); drv(1'b0, 8'h00, 8'h00, 3'h0);
      drv(1'b1, 8'h0b, 8'h00, 3'h0);
      external_irq_pin = 1'b0;
      repeat (3) drv(1'b0, 8'h00, 8'h00, 3'h0);
      note(3'h3, {7'h00, !e[0]}); drv(1'b0, 8'h00, 8'h00, 3'h0);
    end
    tmr(8'h08, 8'h00);
    tmr(8'h0a, 8'h00);
    tmr(8'h00, 8'h00);
    tmr(8'h01, 8'h00);
    tmr(8'h28, 8'h00);
    tmr(8'h38, 8'h00);
    tmr(8'h08, 8'hf8);
    port_latch = 6'h3f;
    drv(1'b1, 8'h81, 8'h88, 3'h0);
    note(3'h6, 8'h00); drv(1'b0, 8'h00, 8'h00, 3'h0);
    drv(1'b0, 8'h00, 8'h00, 3'h0);
    end_of_test();
  end
endmodule // tb_csr_regs
